// file: logic/viu_pkg.sv
// Constants, register map and types of the vectored interrupt unit.
package viu_pkg;

	localparam int NSRC = 32;
	localparam int NSLOT = 16;
	localparam int SRCW = 5;
	localparam int LVLW = NSLOT + 1;
	localparam int ADDRW = 12;
	localparam int EVTW = 3;

	localparam logic [ADDRW-1:0] OFS_NORM_STAT = 12'h000;
	localparam logic [ADDRW-1:0] OFS_FAST_STAT = 12'h004;
	localparam logic [ADDRW-1:0] OFS_RAW_STAT  = 12'h008;
	localparam logic [ADDRW-1:0] OFS_CLASS_SEL = 12'h00C;
	localparam logic [ADDRW-1:0] OFS_EN_SET    = 12'h010;
	localparam logic [ADDRW-1:0] OFS_EN_CLR    = 12'h014;
	localparam logic [ADDRW-1:0] OFS_EVT_STAT  = 12'h018;
	localparam logic [ADDRW-1:0] OFS_EVT_MASK  = 12'h01C;
	localparam logic [ADDRW-1:0] OFS_VEC_ADDR  = 12'h030;
	localparam logic [ADDRW-1:0] OFS_DEF_ADDR  = 12'h034;
	localparam logic [3:0]       PAGE_SLOT_ADDR = 4'h1;
	localparam logic [3:0]       PAGE_SLOT_CTRL = 4'h2;

	localparam int SLOT_EN_BIT = 5;
	localparam int SLOT_SRC_LSB = 0;

	localparam int EVT_FAST_BIT = 0;
	localparam int EVT_NORM_BIT = 1;
	localparam int EVT_DONE_BIT = 2;

	localparam logic [31:0]     RST_WORD = 32'h0000_0000;
	localparam logic [EVTW-1:0] RST_EVT  = 3'h0;
	localparam logic [LVLW-1:0] RST_LVL  = 17'h0_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic            en;
		logic [SRCW-1:0] src;
	} viu_slot_s;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} viu_rd_s;

endpackage

// file: logic/viu_top.sv
// Vectored interrupt unit with AXI4-Lite register access.
//
// The address map and register access over AXI4-Lite were left to the implementer.
module viu_top
	import viu_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rstn,
	// Peripheral request lines.
	input  wire logic [NSRC-1:0]  periph_req,
	// Requests to the processor core.
	output logic                  fast_interrupt_request,
	output logic                  normal_interrupt_request,
	output logic                  evt_irq,
	// AXI4-Lite write address.
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [ADDRW-1:0] s_axi_awaddr,
	// AXI4-Lite write data.
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic [1:0]            s_axi_bresp,
	// AXI4-Lite read address.
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [ADDRW-1:0] s_axi_araddr,
	// AXI4-Lite read data.
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp
);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	logic                  rst_q1_ff;
	logic                  rst_q2_ff;
	logic                  srst_n;

	logic                  aw_full_ff, nxt_aw_full;
	logic [ADDRW-1:0]      aw_addr_ff, nxt_aw_addr;
	logic                  w_full_ff, nxt_w_full;
	logic [31:0]           w_data_ff, nxt_w_data;
	logic [3:0]            w_strb_ff, nxt_w_strb;
	logic                  bvalid_ff, nxt_bvalid;
	logic [1:0]            bresp_ff, nxt_bresp;
	logic                  rvalid_ff, nxt_rvalid;
	viu_rd_s               rd_ff, nxt_rd;

	logic [31:0]           class_sel_ff, nxt_class_sel;
	logic [31:0]           enable_ff, nxt_enable;
	logic [31:0]           def_addr_ff, nxt_def_addr;
	logic [31:0]           slot_addr_ff [NSLOT];
	logic [31:0]           nxt_slot_addr [NSLOT];
	viu_slot_s             slot_ff [NSLOT];
	viu_slot_s             nxt_slot [NSLOT];

	logic [LVLW-1:0]       in_svc_ff, nxt_in_svc;
	logic [EVTW-1:0]       evt_ff, nxt_evt;
	logic [EVTW-1:0]       evt_mask_ff, nxt_evt_mask;
	logic                  fast_ff, nxt_fast;
	logic                  norm_ff, nxt_norm;

	logic                  wr_fire;
	logic                  rd_fire;
	logic                  wr_hit;
	logic                  rd_hit;
	logic [31:0]           rd_word;
	logic [31:0]           masked;
	logic [31:0]           fast_act;
	logic [31:0]           norm_act;
	logic [NSLOT-1:0]      slot_pend;
	logic                  win_any;
	logic [SRCW-2:0]       win_idx;
	logic                  plain_pend;
	logic [31:0]           vec_addr;
	logic [31:0]           slot_map;
	logic                  svc_blk;

	// Reset is released through two flops.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q1_ff <= 1'b0;
			rst_q2_ff <= 1'b0;
		end else begin
			rst_q1_ff <= 1'b1;
			rst_q2_ff <= rst_q1_ff;
		end
	end
	assign srst_n = rst_q2_ff;

	// Classification and arbitration.
	always_comb begin
		masked = periph_req & enable_ff;
		fast_act = masked & class_sel_ff;
		norm_act = masked & ~class_sel_ff;
		slot_map = 32'h0000_0000;
		slot_pend = '0;
		svc_blk = 1'b0;
		for (int i = 0; i < NSLOT; i++) begin
			if (slot_ff[i].en) begin
				slot_pend[i] = norm_act[slot_ff[i].src];
				slot_map[slot_ff[i].src] = 1'b1;
			end
			svc_blk = svc_blk | in_svc_ff[i];
			if (svc_blk) begin
				slot_pend[i] = 1'b0;
			end
		end
		win_any = |slot_pend;
		win_idx = '0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (slot_pend[i]) begin
				win_idx = 4'(i);
			end
		end
		plain_pend = (|(norm_act & ~slot_map)) && !(|in_svc_ff);
		vec_addr = win_any ? slot_addr_ff[win_idx] : def_addr_ff;
		nxt_fast = |fast_act;
		nxt_norm = win_any || plain_pend;
	end

	// Bus handshake signals.
	assign s_axi_awready = !aw_full_ff && !bvalid_ff;
	assign s_axi_wready = !w_full_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_fire = aw_full_ff && w_full_ff && !bvalid_ff;
	assign rd_fire = s_axi_arvalid && !rvalid_ff;

	// Read decode.
	always_comb begin
		rd_word = RST_WORD;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_NORM_STAT: rd_word = norm_act;
			OFS_FAST_STAT: rd_word = fast_act;
			OFS_RAW_STAT:  rd_word = periph_req;
			OFS_CLASS_SEL: rd_word = class_sel_ff;
			OFS_EN_SET:    rd_word = enable_ff;
			OFS_EVT_STAT:  rd_word = {29'h0, evt_ff};
			OFS_EVT_MASK:  rd_word = {29'h0, evt_mask_ff};
			OFS_VEC_ADDR:  rd_word = vec_addr;
			OFS_DEF_ADDR:  rd_word = def_addr_ff;
			default: begin
				if (s_axi_araddr[7:6] == 2'h0 &&
					s_axi_araddr[1:0] == 2'h0 &&
					s_axi_araddr[11:8] == PAGE_SLOT_ADDR) begin
					rd_word = slot_addr_ff[s_axi_araddr[5:2]];
				end else if (s_axi_araddr[7:6] == 2'h0 &&
					s_axi_araddr[1:0] == 2'h0 &&
					s_axi_araddr[11:8] == PAGE_SLOT_CTRL) begin
					rd_word = {26'h0, slot_ff[s_axi_araddr[5:2]]};
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	// Bus channel state.
	always_comb begin
		nxt_aw_full = aw_full_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_full = w_full_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rd = rd_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_full = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_full = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			nxt_aw_full = 1'b0;
			nxt_w_full = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (rd_fire) begin
			nxt_rvalid = 1'b1;
			nxt_rd.data = rd_hit ? rd_word : RST_WORD;
			nxt_rd.resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// Configuration, service level and events.
	always_comb begin
		logic [ADDRW-1:0] a;
		logic             slot_pg;
		logic [EVTW-1:0]  set;
		logic [EVTW-1:0]  clr;
		logic [LVLW-1:0]  pop;
		a = aw_addr_ff;
		slot_pg = a[7:6] == 2'h0 && a[1:0] == 2'h0;
		set = '0;
		clr = '0;
		pop = '0;
		wr_hit = 1'b1;
		nxt_class_sel = class_sel_ff;
		nxt_enable = enable_ff;
		nxt_def_addr = def_addr_ff;
		nxt_slot_addr = slot_addr_ff;
		nxt_slot = slot_ff;
		nxt_in_svc = in_svc_ff;
		nxt_evt_mask = evt_mask_ff;
		// vector read marks level in service
		if (rd_fire && s_axi_araddr == OFS_VEC_ADDR && norm_ff) begin
			if (win_any) begin
				nxt_in_svc[win_idx] = 1'b1;
			end else begin
				nxt_in_svc[NSLOT] = 1'b1;
			end
		end
		unique case (a)
			OFS_CLASS_SEL: nxt_class_sel =
				merge(class_sel_ff, w_data_ff, w_strb_ff);
			OFS_EN_SET: nxt_enable = enable_ff |
				merge(RST_WORD, w_data_ff, w_strb_ff);
			OFS_EN_CLR: nxt_enable = enable_ff &
				~merge(RST_WORD, w_data_ff, w_strb_ff);
			OFS_EVT_STAT: clr = w_strb_ff[0] ? w_data_ff[EVTW-1:0] : '0;
			OFS_EVT_MASK: begin
				if (w_strb_ff[0]) begin
					nxt_evt_mask = w_data_ff[EVTW-1:0];
				end
			end
			OFS_DEF_ADDR: nxt_def_addr =
				merge(def_addr_ff, w_data_ff, w_strb_ff);
			OFS_VEC_ADDR: begin
				// end of service pops one level
				for (int i = LVLW - 1; i >= 0; i--) begin
					if (in_svc_ff[i]) begin
						pop = LVLW'(1) << i;
					end
				end
				set[EVT_DONE_BIT] = 1'b1;
			end
			OFS_NORM_STAT, OFS_FAST_STAT, OFS_RAW_STAT: ;
			default: begin
				if (slot_pg && a[11:8] == PAGE_SLOT_ADDR) begin
					nxt_slot_addr[a[5:2]] = merge(slot_addr_ff[a[5:2]],
						w_data_ff, w_strb_ff);
				end else if (slot_pg && a[11:8] == PAGE_SLOT_CTRL) begin
					if (w_strb_ff[0]) begin
						nxt_slot[a[5:2]].en = w_data_ff[SLOT_EN_BIT];
						nxt_slot[a[5:2]].src =
							w_data_ff[SLOT_SRC_LSB +: SRCW];
					end
				end else begin
					wr_hit = 1'b0;
				end
			end
		endcase
		if (!wr_fire) begin
			nxt_class_sel = class_sel_ff;
			nxt_enable = enable_ff;
			nxt_def_addr = def_addr_ff;
			nxt_slot_addr = slot_addr_ff;
			nxt_slot = slot_ff;
			nxt_evt_mask = evt_mask_ff;
			pop = '0;
			set = '0;
			clr = '0;
		end
		// A pop is applied after a level marked by a read in the same cycle, and clears it if both are the same bit.
		nxt_in_svc = nxt_in_svc & ~pop;
		set[EVT_FAST_BIT] = nxt_fast && !fast_ff;
		set[EVT_NORM_BIT] = nxt_norm && !norm_ff;
		// Event set wins over a clear in the same cycle.
		nxt_evt = (evt_ff & ~clr) | set;
	end

	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_full_ff <= 1'b0;
			w_data_ff <= RST_WORD;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rd_ff <= '0;
			class_sel_ff <= RST_WORD;
			enable_ff <= RST_WORD;
			def_addr_ff <= RST_WORD;
			for (int i = 0; i < NSLOT; i++) begin
				slot_addr_ff[i] <= RST_WORD;
				slot_ff[i] <= '0;
			end
			in_svc_ff <= RST_LVL;
			evt_ff <= RST_EVT;
			evt_mask_ff <= RST_EVT;
			fast_ff <= 1'b0;
			norm_ff <= 1'b0;
		end else begin
			aw_full_ff <= nxt_aw_full;
			aw_addr_ff <= nxt_aw_addr;
			w_full_ff <= nxt_w_full;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rd_ff <= nxt_rd;
			class_sel_ff <= nxt_class_sel;
			enable_ff <= nxt_enable;
			def_addr_ff <= nxt_def_addr;
			slot_addr_ff <= nxt_slot_addr;
			slot_ff <= nxt_slot;
			in_svc_ff <= nxt_in_svc;
			evt_ff <= nxt_evt;
			evt_mask_ff <= nxt_evt_mask;
			fast_ff <= nxt_fast;
			norm_ff <= nxt_norm;
		end
	end

	assign fast_interrupt_request = fast_ff;
	assign normal_interrupt_request = norm_ff;
	assign evt_irq = |(evt_ff & evt_mask_ff);
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rd_ff.data;
	assign s_axi_rresp = rd_ff.resp;

endmodule

// file: testbench/viu_periph_model.sv
// Peripheral side model: one held request line per peripheral.
module viu_periph_model
	import viu_pkg::*;
(
	// Clock.
	input  wire logic            clk,
	// Line control from the bench.
	input  wire logic [NSRC-1:0] raise,
	input  wire logic [NSRC-1:0] drop,
	// Request lines.
	output logic      [NSRC-1:0] periph_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial periph_req = '0;
	always @(posedge clk)
		periph_req <= (periph_req | raise) & ~drop;
endmodule

// file: testbench/viu_properties.sv
// Port assertions of the vectored interrupt unit.
module viu_checker
	import viu_pkg::*;
(
	// Clock, reset and requests.
	input wire logic            clk,
	input wire logic            rstn,
	input wire logic [NSRC-1:0] periph_req,
	input wire logic            fast_interrupt_request,
	input wire logic            normal_interrupt_request,
	// Register bus.
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	fast_cause_a:
	assert property ($rose(fast_interrupt_request) |-> |$past(periph_req))
		else $error("fast request with no line up");
	fast_idle_a:
	assert property (periph_req == '0 |=> !fast_interrupt_request)
		else $error("fast request while all lines low");
	norm_cause_a:
	assert property ($rose(normal_interrupt_request) |-> |$past(periph_req))
		else $error("normal request with no line up");
	norm_idle_a:
	assert property (periph_req == '0 |=> !normal_interrupt_request)
		else $error("normal request while all lines low");
	write_resp_a:
	assert property (wr_taken |=> ##[0:2] s_axi_bvalid)
		else $error("write response missing");
	write_retire_a:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	read_resp_a:
	assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data missing");
	read_retire_a:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not retired");
endmodule

bind viu_top viu_checker i_chk (.*);

// file: testbench/test_viu_top.sv
// Register level bench of the vectored interrupt unit.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_viu_top
	import viu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk = 1'h0;
	logic             rstn = 1'h0;
	logic [NSRC-1:0]  raise = '0;
	logic [NSRC-1:0]  drop = '1;
	logic [NSRC-1:0]  periph_req;
	logic             fast_interrupt_request;
	logic             normal_interrupt_request;
	logic             evt_irq;
	logic             s_axi_awvalid = 1'h0;
	logic             s_axi_awready;
	logic [ADDRW-1:0] s_axi_awaddr = '0;
	logic             s_axi_wvalid = 1'h0;
	logic             s_axi_wready;
	logic [31:0]      s_axi_wdata = '0;
	logic [3:0]       s_axi_wstrb = 4'hF;
	logic             s_axi_bvalid;
	logic             s_axi_bready = 1'h0;
	logic [1:0]       s_axi_bresp;
	logic             s_axi_arvalid = 1'h0;
	logic             s_axi_arready;
	logic [ADDRW-1:0] s_axi_araddr = '0;
	logic             s_axi_rvalid;
	logic             s_axi_rready = 1'h0;
	logic [31:0]      s_axi_rdata;
	logic [1:0]       s_axi_rresp;
	int               errors = 0;
	int               checked = 0;
	int               cyc = 0;

	viu_top i_viu_top (.*);
	viu_periph_model i_viu_periph_model (.*);

	always #50 clk = ~clk;

	task automatic end_sim();
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			end_sim();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic req(input logic [NSRC-1:0] up, input logic [NSRC-1:0] dn);
		@(posedge clk);
		raise <= up;
		drop <= dn;
		@(posedge clk);
		raise <= '0;
		drop <= '0;
		tick(3);
	endtask

	task automatic wr(input logic [ADDRW-1:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic pa = 1'h1;
		logic pw = 1'h1;
		logic pb = 1'h1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (pb) begin
			@(posedge clk);
			if (pa && s_axi_awready) begin
				pa = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (pw && s_axi_wready) begin
				pw = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			if (s_axi_bvalid) begin
				pb = 1'h0;
				s_axi_bready <= 1'h0;
				`CHK(s_axi_bresp, er)
			end
		end
	endtask

	task automatic rc(input logic [ADDRW-1:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		logic p = 1'h1;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (p) begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				p = 1'h0;
				s_axi_rready <= 1'h0;
				`CHK(s_axi_rdata, e)
				`CHK(s_axi_rresp, er)
			end
		end
	endtask

	initial begin
		tick(6);
		rstn <= 1'h1;
		tick(3);
		rc(OFS_CLASS_SEL, '0);
		rc(OFS_EN_SET, '0);
		rc(OFS_DEF_ADDR, '0);
		rc(12'h0F0, '0, RESP_SLVERR);
		wr(12'h0F0, '1, RESP_SLVERR);
		wr(OFS_CLASS_SEL, 32'h0000_0088);
		wr(OFS_EN_SET, 32'h0030_0288);
		wr(OFS_EN_CLR, 32'h0000_0080);
		rc(OFS_EN_SET, 32'h0030_0208);
		wr(12'h100, 32'h0000_00A0);
		wr(12'h13C, 32'h0000_00AF);
		wr(12'h200, 32'h0000_0034);
		wr(12'h23C, 32'h0000_0035);
		wr(OFS_DEF_ADDR, 32'h0000_00DD);
		rc(12'h13C, 32'h0000_00AF);
		rc(12'h23C, 32'h0000_0035);
		req(32'h0000_0088, '0);
		`CHK(fast_interrupt_request, 1'h1);
		`CHK(normal_interrupt_request, 1'h0);
		`CHK(evt_irq, 1'h0);
		rc(OFS_FAST_STAT, 32'h0000_0008);
		rc(OFS_RAW_STAT, 32'h0000_0088);
		rc(OFS_EVT_STAT, 32'h0000_0001);
		wr(OFS_EVT_MASK, 32'h0000_0001);
		tick(2);
		`CHK(evt_irq, 1'h1);
		wr(OFS_EVT_STAT, 32'h0000_0007);
		tick(2);
		`CHK(evt_irq, 1'h0);
		req('0, 32'h0000_0008);
		`CHK(fast_interrupt_request, 1'h0);
		req(32'h0000_0200, '0);
		`CHK(normal_interrupt_request, 1'h1);
		rc(OFS_NORM_STAT, 32'h0000_0200);
		wr(OFS_CLASS_SEL, 32'h0000_0288);
		tick(3);
		`CHK(fast_interrupt_request, 1'h1);
		`CHK(normal_interrupt_request, 1'h0);
		wr(OFS_CLASS_SEL, 32'h0000_0088);
		req(32'h0020_0000, '0);
		rc(OFS_VEC_ADDR, 32'h0000_00AF);
		tick(3);
		`CHK(normal_interrupt_request, 1'h0);
		wr(OFS_VEC_ADDR, '0);
		tick(3);
		`CHK(normal_interrupt_request, 1'h1);
		req(32'h0010_0000, '0);
		rc(OFS_VEC_ADDR, 32'h0000_00A0);
		wr(OFS_VEC_ADDR, '0);
		req('0, 32'h0010_0000);
		rc(OFS_VEC_ADDR, 32'h0000_00AF);
		wr(OFS_VEC_ADDR, '0);
		req('0, 32'h0020_0000);
		rc(OFS_VEC_ADDR, 32'h0000_00DD);
		wr(OFS_VEC_ADDR, '0);
		rc(OFS_EVT_STAT, 32'h0000_0007);
		`CHK(evt_irq, 1'h1);
		end_sim();
	end
endmodule
